// >>> lvds_serdes.sv
// Contract
// - converter clock is the reference multiplied by 4, 7 or 8 per mode
// - receive multiplier turns 77.76 MHz reference into 622.08 MHz bits
// - receive bit strobes land just after the start of each bit slot
// - each lane goes through 8:1, 7:1, 4:1 deserializer or bypasses it
// - 1:1 mode skips conversion and hands raw lane bits to logic_cells
// - receive side offers a 1x clock for general logic
// - transmit reference is the external pin or the receive 1x clock
// - forwarded transmit 1x clock is in phase with the serial lanes
// - up to 16 receive lanes form a word of up to 128 bits
// - up to 128 parallel bits leave on 16 lanes, 8:1 per lane
// - dedicated multipliers never multiply by more than eight
// - each slow clock cycle moves one whole word each direction
// - every receive lane has its own shift register; transmit lanes pick bits from a held word
// - receive and transmit use separate clock multipliers
// - received data lags the reference edge by two bit periods
`timescale 1ns/1ns
`include "lvds_serdes_params.svh"

module lvds_serdes (
	input  wire logic                       core_clk_i,
	input  wire logic                       srst_i,
	input  wire logic                       rx_ref_clk_i,
	input  wire logic [`LANES-1:0]          rx_lane_i,
	input  wire lvds_serdes_pkg::conv_mode_t rx_mode_i,
	output logic      [`WORD_W-1:0]         rx_word_o,
	output logic                            rx_word_valid_o,
	output logic      [`LANES-1:0]          rx_bypass_o,
	output logic                            rx_bypass_valid_o,
	output logic                            rx_clk1x_o,
	output logic                            rx_locked_o,
	input  wire logic                       tx_ref_clk_i,
	input  wire logic                       tx_ref_sel_i,
	input  wire lvds_serdes_pkg::conv_mode_t tx_mode_i,
	input  wire logic [`WORD_W-1:0]         tx_word_i,
	output logic                            tx_load_o,
	output logic      [`LANES-1:0]          tx_lane_o,
	output logic                            tx_clk_o,
	output logic                            tx_locked_o
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// ratio per mode; clamped so no mode can exceed the multiplier limit
	function automatic logic [`RATIO_W-1:0] ratio_of(
		input lvds_serdes_pkg::conv_mode_t m
	);
		logic [`RATIO_W-1:0] r;
		case (m)
			lvds_serdes_pkg::MODE_X4: r = `RATIO_X4;
			lvds_serdes_pkg::MODE_X7: r = `RATIO_X7;
			lvds_serdes_pkg::MODE_X8: r = `RATIO_X8;
			default:                  r = `RATIO_BYPASS;
		endcase
		if (r > `RATIO_W'(`MAX_RATIO)) begin
			r = `RATIO_W'(`MAX_RATIO);
		end
		return r;
	endfunction

	// reference tracker: two-flop sync, edge find, period measure, lock
	function automatic lvds_serdes_pkg::clk_track_t track_next(
		input lvds_serdes_pkg::clk_track_t c,
		input logic                        pin
	);
		lvds_serdes_pkg::clk_track_t n;
		logic                        rise;
		n = c;
		rise = c.ref_sync[1] & ~c.ref_prev;
		n.ref_sync = {c.ref_sync[0], pin};
		n.ref_prev = c.ref_sync[1];
		if (rise) begin
			n.t = '0;
			n.slot = '0;
			n.period = c.t + `CNT_W'(1);
		end else if (c.t != `CNT_MAX) begin
			n.t = c.t + `CNT_W'(1);
		end
		// a stopped reference saturates the count and drops lock
		case (c.lock)
			lvds_serdes_pkg::LOCK_IDLE: begin
				if (rise) begin
					n.lock = lvds_serdes_pkg::LOCK_MEAS;
				end
			end
			lvds_serdes_pkg::LOCK_MEAS: begin
				if (rise) begin
					n.lock = lvds_serdes_pkg::LOCK_HELD;
				end else if (c.t == `CNT_MAX) begin
					n.lock = lvds_serdes_pkg::LOCK_IDLE;
				end
			end
			lvds_serdes_pkg::LOCK_HELD: begin
				if (c.t == `CNT_MAX) begin
					n.lock = lvds_serdes_pkg::LOCK_IDLE;
				end
			end
			default: n.lock = lvds_serdes_pkg::LOCK_IDLE;
		endcase
		return n;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	lvds_serdes_pkg::core_state_t r;
	lvds_serdes_pkg::core_state_t next_r;

	// ------------------------------------------------------------
	// receive path
	// ------------------------------------------------------------
	logic [`RATIO_W-1:0] rx_ratio;
	logic [`PROD_W-1:0]  rx_lhs;
	logic [`PROD_W-1:0]  rx_rhs;
	logic                rx_rise;
	logic                rx_hit;
	logic [`CNT_W-1:0]   rx_ph;
	logic [3:0]          rx_slot;
	logic [`RATIO_W-1:0] rx_bit;
	logic [`LANE_BITS-1:0] rx_mask;

	// multiplied strobe: slot j taken in the cycle holding j*period/ratio
	always_comb begin
		rx_ratio = ratio_of(rx_mode_i);
		rx_rise = r.rx.trk.ref_sync[1] & ~r.rx.trk.ref_prev;
		// phase 0 is the edge-detect cycle, so a frame has period samples
		rx_ph = rx_rise ? '0 : r.rx.trk.t + `CNT_W'(1);
		rx_slot = rx_rise ? 4'h0 : r.rx.trk.slot;
		rx_lhs = `PROD_W'(rx_ph) * `PROD_W'(rx_ratio)
			+ `PROD_W'(rx_ratio);
		rx_rhs = `PROD_W'(rx_slot) * `PROD_W'(r.rx.trk.period);
		// bit strobe at ratio times ref
		// strobe inside the bit window
		// late-cycle sample lands just after the slot start; limitation:
		// window margin depends on the pin-to-clock offset
		rx_hit = (r.rx.trk.lock == lvds_serdes_pkg::LOCK_HELD)
			&& (rx_slot < rx_ratio) && (rx_lhs > rx_rhs);
		rx_bit = rx_slot + rx_ratio - `LAG_BITS;
		if (rx_bit >= rx_ratio) begin
			rx_bit = rx_bit - rx_ratio;
		end
		rx_mask = ~({`LANE_BITS{1'b1}} << rx_ratio);
	end

	// ------------------------------------------------------------
	// transmit path
	// ------------------------------------------------------------
	logic [`RATIO_W-1:0] tx_ratio;
	logic                tx_pin;
	logic [`PROD_W-1:0]  tx_lhs;
	logic [`PROD_W-1:0]  tx_rhs;
	logic                tx_rise;
	logic                tx_hit;
	logic [`CNT_W-1:0]   tx_ph;
	logic [3:0]          tx_slot;
	logic [2:0]          tx_idx;

	// slot j starts where phase*ratio >= j*period, phase 0 at the edge
	always_comb begin
		tx_ratio = ratio_of(tx_mode_i);
		tx_pin = tx_ref_sel_i ? r.rx.clk1x : tx_ref_clk_i;
		tx_rise = r.tx.trk.ref_sync[1] & ~r.tx.trk.ref_prev;
		tx_ph = tx_rise ? '0 : r.tx.trk.t + `CNT_W'(1);
		tx_slot = tx_rise ? 4'h0 : r.tx.trk.slot;
		tx_lhs = `PROD_W'(tx_ph) * `PROD_W'(tx_ratio);
		tx_rhs = `PROD_W'(tx_slot) * `PROD_W'(r.tx.trk.period);
		// a word only starts on a detected edge, so clock and data agree
		tx_hit = (r.tx.trk.lock == lvds_serdes_pkg::LOCK_HELD)
			&& (tx_slot < tx_ratio) && (tx_lhs >= tx_rhs)
			&& (tx_rise || tx_slot != 4'h0);
		tx_idx = 3'(tx_ratio - `RATIO_W'(1) - tx_slot);
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.rx.trk = track_next(r.rx.trk, rx_ref_clk_i);
		next_r.tx.trk = track_next(r.tx.trk, tx_pin);
		// lane pins are asynchronous: only lane_s2 feeds logic
		next_r.rx.lane_s1 = rx_lane_i;
		next_r.rx.lane_s2 = r.rx.lane_s1;
		next_r.rx.word_valid = 1'b0;
		next_r.rx.bypass_valid = 1'b0;
		next_r.tx.load = 1'b0;
		next_r.rx.clk1x = r.rx.trk.ref_sync[1];

		if (rx_hit) begin
			next_r.rx.trk.slot = rx_slot + 4'h1;
			if (rx_mode_i == lvds_serdes_pkg::MODE_BYPASS) begin
				next_r.rx.bypass = r.rx.lane_s2;
				next_r.rx.bypass_valid = 1'b1;
			end else begin
				for (int n = 0; n < `LANES; n++) begin
					next_r.rx.shreg[n] = {r.rx.shreg[n][`LANE_BITS-2:0],
						r.rx.lane_s2[n]};
				end
				if (rx_bit == rx_ratio - `RATIO_W'(1)) begin
					for (int n = 0; n < `LANES; n++) begin
						next_r.rx.word[n] = next_r.rx.shreg[n] & rx_mask;
					end
					next_r.rx.word_valid = 1'b1;
				end
			end
		end

		if (tx_hit) begin
			next_r.tx.trk.slot = tx_slot + 4'h1;
			if (tx_slot == 4'h0) begin
				next_r.tx.hold = tx_word_i;
				next_r.tx.load = 1'b1;
				for (int n = 0; n < `LANES; n++) begin
					// first bit leaves with the edge
					next_r.tx.lane[n] = tx_word_i[n*`LANE_BITS
						+ int'(tx_idx)];
				end
			end else begin
				for (int n = 0; n < `LANES; n++) begin
					next_r.tx.lane[n] = r.tx.hold[n][tx_idx];
				end
			end
		end else if (r.tx.trk.lock != lvds_serdes_pkg::LOCK_HELD) begin
			next_r.tx.lane = '0;
		end
		next_r.tx.clk_fwd = r.tx.trk.ref_sync[1];
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// outputs, all from flops
	// ------------------------------------------------------------
	assign rx_word_o         = r.rx.word;
	assign rx_word_valid_o   = r.rx.word_valid;
	assign rx_bypass_o       = r.rx.bypass;
	assign rx_bypass_valid_o = r.rx.bypass_valid;
	assign rx_clk1x_o        = r.rx.clk1x;
	assign rx_locked_o       = (r.rx.trk.lock == lvds_serdes_pkg::LOCK_HELD);
	assign tx_load_o         = r.tx.load;
	assign tx_lane_o         = r.tx.lane;
	assign tx_clk_o          = r.tx.clk_fwd;
	assign tx_locked_o       = (r.tx.trk.lock == lvds_serdes_pkg::LOCK_HELD);

endmodule

// >>> lvds_serdes_params.svh
`ifndef LVDS_SERDES_PARAMS_SVH
`define LVDS_SERDES_PARAMS_SVH

// ----------------------------------------------------------------
// lane geometry
// ----------------------------------------------------------------
`define LANES          16
`define LANE_BITS      8
`define WORD_W         128

// ----------------------------------------------------------------
// conversion ratios and clock multiplication
// ----------------------------------------------------------------
`define RATIO_W        4
`define RATIO_BYPASS   4'h1
`define RATIO_X4       4'h4
`define RATIO_X7       4'h7
`define RATIO_X8       4'h8
// nominal receive reference and bit clock, in kHz
`define RX_REF_KHZ     77760
`define RX_BIT_KHZ     622080
// highest multiplication the dedicated multipliers allow
`define MAX_RATIO      (`RX_BIT_KHZ / `RX_REF_KHZ)
// receive data lags the reference edge by this many bit periods
`define LAG_BITS       4'h2

// ----------------------------------------------------------------
// reference period tracking
// ----------------------------------------------------------------
`define CNT_W          12
`define PROD_W         17
`define CNT_MAX        12'hFFF

`endif

// >>> lvds_serdes_pkg.sv
`include "lvds_serdes_params.svh"

package lvds_serdes_pkg;

	// ------------------------------------------------------------
	// modes and lock states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_BYPASS = 2'h0,
		MODE_X4     = 2'h1,
		MODE_X7     = 2'h2,
		MODE_X8     = 2'h3
	} conv_mode_t;

	typedef enum logic [1:0] {
		LOCK_IDLE = 2'h0,
		LOCK_MEAS = 2'h1,
		LOCK_HELD = 2'h2
	} lock_t;

	// ------------------------------------------------------------
	// carriers and state
	// ------------------------------------------------------------
	typedef logic [`LANES-1:0][`LANE_BITS-1:0] lane_word_t;

	typedef struct packed {
		logic [1:0]        ref_sync;
		logic              ref_prev;
		logic [`CNT_W-1:0] t;
		logic [`CNT_W-1:0] period;
		logic [3:0]        slot;
		lock_t             lock;
	} clk_track_t;

	typedef struct packed {
		clk_track_t        trk;
		logic [`LANES-1:0] lane_s1;
		logic [`LANES-1:0] lane_s2;
		lane_word_t        shreg;
		lane_word_t        word;
		logic              word_valid;
		logic [`LANES-1:0] bypass;
		logic              bypass_valid;
		logic              clk1x;
	} rx_state_t;

	typedef struct packed {
		clk_track_t        trk;
		lane_word_t        hold;
		logic [`LANES-1:0] lane;
		logic              clk_fwd;
		logic              load;
	} tx_state_t;

	typedef struct packed {
		rx_state_t rx;
		tx_state_t tx;
	} core_state_t;

endpackage

// >>> lvds_serdes_props.sv
`timescale 1ns/1ns
`include "lvds_serdes_params.svh"
module lvds_serdes_props (
	input wire logic                        core_clk_i,
	input wire logic                        srst_i,
	input wire lvds_serdes_pkg::conv_mode_t rx_mode_i,
	input wire logic [`WORD_W-1:0]          rx_word_o,
	input wire logic                        rx_word_valid_o,
	input wire logic                        rx_bypass_valid_o,
	input wire logic                        rx_locked_o,
	input wire logic                        tx_load_o,
	input wire logic                        tx_clk_o,
	input wire logic [`LANES-1:0]           tx_lane_o,
	input wire logic                        tx_locked_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// ----------------------------------------------------------
	// receive side
	// ----------------------------------------------------------
	AST_RX_SPACING: assert property (
		rx_word_valid_o |=> !rx_word_valid_o [*5]) else $error("rx burst");
	AST_RX_HOLD: assert property (
		!rx_word_valid_o |-> $stable(rx_word_o)) else $error("rx word moved");
	AST_RX_NARROW: assert property (
		rx_word_valid_o |-> !(rx_mode_i == lvds_serdes_pkg::MODE_X4
		&& |(rx_word_o & {16{8'hF0}})) && !(rx_mode_i ==
		lvds_serdes_pkg::MODE_X7 && |(rx_word_o & {16{8'h80}})))
		else $error("rx upper bits set");
	AST_RX_LOCKED: assert property (
		rx_word_valid_o |-> $past(rx_locked_o)) else $error("rx unlocked");
	AST_BYPASS_MODE: assert property (
		rx_bypass_valid_o |-> rx_mode_i == lvds_serdes_pkg::MODE_BYPASS)
		else $error("bypass out of mode");
	AST_WORD_MODE: assert property (
		rx_word_valid_o |-> rx_mode_i != lvds_serdes_pkg::MODE_BYPASS)
		else $error("word in bypass");
	// ----------------------------------------------------------
	// transmit side, then cover points
	// ----------------------------------------------------------
	AST_TX_PHASE: assert property (
		tx_load_o |-> $rose(tx_clk_o)) else $error("tx clock out of phase");
	AST_TX_LOCKED: assert property (
		tx_load_o |-> tx_locked_o) else $error("tx load unlocked");
	AST_TX_QUIET: assert property (
		!tx_locked_o ##1 !tx_locked_o |-> tx_lane_o == 16'h0000)
		else $error("tx lanes busy unlocked");
	COV_RX: cover property (rx_word_valid_o);
	COV_BYP: cover property (rx_bypass_valid_o);
	COV_TX: cover property (tx_load_o);
endmodule
bind lvds_serdes lvds_serdes_props u_props (.*);

// >>> lvds_far_end.sv
`timescale 1ns/1ns
`include "lvds_serdes_params.svh"
module lvds_far_end (
	input  wire lvds_serdes_pkg::conv_mode_t mode_i,
	input  wire logic [`WORD_W-1:0]          data_i,
	output logic                             ref_clk_o,
	output logic      [`LANES-1:0]           lane_o
);
	// free running reference; offset keeps lane edges off rising core edges
	initial begin
		ref_clk_o = 1'b0;
		lane_o = 16'h0000;
		#6;
		forever #40 ref_clk_o = ~ref_clk_o;
	end
	task automatic send(input logic [`WORD_W-1:0] w, input int r);
		int k;
		int n;
		#(160 / r);
		for (k = 0; k < r; k++) begin
			for (n = 0; n < `LANES; n++)
				lane_o[n] = w[8 * n + r - 1 - k];
			// integer edges avoid drift at 7 bits
			#((k + 3) * 80 / r - (k + 2) * 80 / r);
		end
	endtask
	// one frame per reference edge, msb first
	always @(posedge ref_clk_o) begin
		fork
			send(data_i, mode_i == lvds_serdes_pkg::MODE_X8 ? 8 :
				mode_i == lvds_serdes_pkg::MODE_X7 ? 7 :
				mode_i == lvds_serdes_pkg::MODE_X4 ? 4 : 1);
		join_none
	end
endmodule

// >>> tb_lvds_serdes.sv
`timescale 1ns/1ns
`include "lvds_serdes_params.svh"
module tb_lvds_serdes;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic rx_ref;
	logic [15:0] rx_lane;
	lvds_serdes_pkg::conv_mode_t rx_mode = lvds_serdes_pkg::MODE_X8;
	logic tx_ref = 1'b0;
	logic tx_sel = 1'b0;
	logic [127:0] tx_word = 128'h0;
	logic [127:0] data = 128'h0;
	logic [127:0] rx_word, txw, v;
	logic [15:0] rx_byp, tx_lane, l;
	logic rx_val, byp_val, rx_locked, tx_load, tx_locked;
	int n_fail = 0;
	int samples_checked = 0;
	int c = 8;
	int n_1x = 0;
	logic clk1x;
	logic p1x = 1'b0;
	logic [127:0] q[$];
	bit started, sending;
	always #5 core_clk = ~core_clk;
	always #40 tx_ref = ~tx_ref;
	lvds_serdes u_dut (.core_clk_i(core_clk), .srst_i(srst),
		.rx_ref_clk_i(rx_ref), .rx_lane_i(rx_lane), .rx_mode_i(rx_mode),
		.rx_word_o(rx_word), .rx_word_valid_o(rx_val), .rx_bypass_o(rx_byp),
		.rx_bypass_valid_o(byp_val), .rx_clk1x_o(clk1x),
		.rx_locked_o(rx_locked),
		.tx_ref_clk_i(tx_ref), .tx_ref_sel_i(tx_sel),
		.tx_mode_i(rx_mode), .tx_word_i(tx_word),
		.tx_load_o(tx_load), .tx_lane_o(tx_lane), .tx_clk_o(),
		.tx_locked_o(tx_locked));
	lvds_far_end u_far (.mode_i(rx_mode), .data_i(data),
		.ref_clk_o(rx_ref), .lane_o(rx_lane));
	task check(input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function automatic logic [127:0] model(input logic [127:0] w);
		logic [127:0] e;
		int n;
		e = 128'h0;
		for (n = 0; n < 16; n++) begin
			case (rx_mode)
				lvds_serdes_pkg::MODE_BYPASS: e[n] = w[8 * n];
				lvds_serdes_pkg::MODE_X4: e[8 * n +: 4] = w[8 * n +: 4];
				lvds_serdes_pkg::MODE_X7: e[8 * n +: 7] = w[8 * n +: 7];
				default: e[8 * n +: 8] = w[8 * n +: 8];
			endcase
		end
		return e;
	endfunction
	// fresh far end word each reference period
	always @(negedge rx_ref) begin
		data = sending ? {$urandom, $urandom, $urandom, $urandom | 1} : 128'h0;
		if (sending)
			q.push_back(model(data));
	end
	// bypass words captured on the general core clock
	// receive monitor, starts at first nonzero word
	always @(negedge core_clk) begin
		if ((rx_val === 1'b1 || byp_val === 1'b1) && q.size() > 0) begin
			v = rx_val ? rx_word : {112'h0, rx_byp};
			if (started || v !== 128'h0) begin
				started = 1;
				check(v, q.pop_front());
			end
		end
	end
	// transmit stream, new word once each load is taken
	always @(posedge core_clk)
		if (tx_load === 1'b1)
			tx_word <= {$urandom, $urandom, $urandom, $urandom};
	// bits per lane for a mode
	function automatic int rat(input lvds_serdes_pkg::conv_mode_t m);
		return m == lvds_serdes_pkg::MODE_X8 ? 8 :
			m == lvds_serdes_pkg::MODE_X7 ? 7 :
			m == lvds_serdes_pkg::MODE_X4 ? 4 : 1;
	endfunction
	// count 1x clock rises, one per reference period
	always @(negedge core_clk) begin
		if (clk1x === 1'b1 && p1x === 1'b0)
			n_1x++;
		p1x = clk1x;
	end
	// msb first lanes, slots spread evenly over eight cycles
	always @(negedge core_clk) begin
		if (tx_load === 1'b1) begin
			txw = tx_word;
			c = 0;
		end
		if (srst === 1'b1)
			c = 8;
		if (c < 8) begin
			for (int n = 0; n < 16; n++)
				l[n] = txw[8 * n + rat(rx_mode) - 1
					- c * rat(rx_mode) / 8];
			check(tx_lane, l);
			c++;
		end
	end
	task automatic run(input lvds_serdes_pkg::conv_mode_t m, input logic s);
		int i;
		@(posedge core_clk);
		srst <= 1'b1;
		rx_mode <= m;
		tx_sel <= s;
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		started = 0;
		q.delete();
		for (i = 0; i < 300 && rx_locked !== 1'b1; i++)
			@(posedge core_clk);
		check(rx_locked, 1'b1);
		repeat (40) @(posedge core_clk);
		sending = 1;
		n_1x = 0;
		repeat (120) @(posedge core_clk);
		check(n_1x, 15);
		sending = 0;
		repeat (60) @(posedge core_clk);
		check(q.size(), 128'h0);
		check(tx_locked, 1'b1);
		$display("mode %0d select %0d done", m, s);
	endtask
	initial begin
		void'($urandom(32'hA7CA0CAB));
		run(lvds_serdes_pkg::MODE_X8, 1'b1);
		run(lvds_serdes_pkg::MODE_X7, 1'b0);
		run(lvds_serdes_pkg::MODE_X4, 1'b1);
		run(lvds_serdes_pkg::MODE_BYPASS, 1'b0);
		results();
	end
	// hang guard, far beyond four short runs
	initial begin
		#100000;
		n_fail++;
		results();
	end
endmodule
